// ---- rtl/cums_mixed_status.sv ----
// Summary of operation
// - set clock switch done when switch to half internal clock completes.
// - clear clock switch done on switch back, power-on, or uart reset.
// - fifo empty flag high while receive fifo empty; one after reset.
// - in T=1 restart 22 etu counter per start bit; set guard flag.
// - in T=0 restart 16 etu counter per start bit; set guard flag.
// - card present bit follows the presence contact.
// - set tx/rx flag when uart enters transmission mode.
// - set tx/rx flag per sent char, except clean last char mode.
// - set tx/rx flag when receive fifo reaches programmed length.
// - clear tx/rx flag at power-on and while uart held in reset.
// - clear tx/rx flag on transmit data write or receive data read.
// - clear tx/rx flag when uart goes back to reception mode.
// - mixed status readable at Ch, flags in bits 7,6,5,2,0.
// - writes to Ch load fifo control; reads at Ch return status.
// - drive host_irq_n low when tx/rx flag set and unmasked.
// - access-caused tx/rx flag clear takes effect three cycles later.
module cums_mixed_status (
  input wire logic ref_clk,
  input wire logic srst,
  // peripheral bus, one-cycle strobes
  input wire logic [3:0] per_addr,
  input wire logic per_rd,
  input wire logic per_wr,
  input wire logic [7:0] per_wdata,
  output logic [7:0] per_rdata,
  // uart core, same clock
  input wire logic uart_reset_release,
  input wire logic clk_switch_int_done,
  input wire logic clk_switch_xtal_done,
  input wire logic [3:0] rx_fifo_level,
  input wire logic etu_tick,
  input wire logic protocol_t1,
  input wire logic tx_mode,
  input wire logic tx_char_done,
  input wire logic tx_parity_error,
  input wire logic last_char_mode,
  input wire logic tx_rx_flag_mask,
  // pins
  input wire logic card_io_pin,
  input wire logic card_present_pin,
  // outputs
  output logic [2:0] parity_error_count,
  output logic [2:0] fifo_length,
  output logic tx_data_write,
  output logic rx_data_read,
  output logic host_irq_n
);
  logic io_meta, io_sync, io_prev;
  logic pres_meta, pres_sync;
  logic start_bit;
  logic tx_mode_prev;
  logic rx_full_prev;
  logic rx_full;
  logic [cums_pkg::CLEAR_DELAY_CYCLES-1:0] clear_pipe;
  logic clock_switch_done;
  logic rx_fifo_empty;
  logic block_guard_flag;
  logic card_present;
  logic tx_empty_rx_full;
  logic set_flag;
  logic clear_flag;
  logic [7:0] mixed_status_reg;
  logic [4:0] guard_limit;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      io_meta <= 1'b1;
      io_sync <= 1'b1;
      io_prev <= 1'b1;
      pres_meta <= 1'b0;
      pres_sync <= 1'b0;
    end else begin
      io_meta <= card_io_pin;
      io_sync <= io_meta;
      io_prev <= io_sync;
      pres_meta <= card_present_pin;
      pres_sync <= pres_meta;
    end
  end

  // a start bit is a falling edge on the idle-high line
  assign start_bit = io_prev && !io_sync;

  // -----------------------------------------------------------------
  // bus strobes and fifo control
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_data_write <= 1'b0;
      rx_data_read <= 1'b0;
    end else begin
      tx_data_write <= per_wr && (per_addr == cums_pkg::ADDR_TX_RX_DATA);
      rx_data_read <= per_rd && (per_addr == cums_pkg::ADDR_TX_RX_DATA);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      parity_error_count <= cums_pkg::FCR_PEC_RESET;
      fifo_length <= cums_pkg::FCR_FL_RESET;
    end else if (per_wr && (per_addr == cums_pkg::ADDR_FIFO_CONTROL)) begin
      parity_error_count <= per_wdata[cums_pkg::FCR_PEC_LSB +: 3];
      fifo_length <= per_wdata[cums_pkg::FCR_FL_LSB +: 3];
    end
  end

  // -----------------------------------------------------------------
  // clock switch done
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clock_switch_done <= 1'b0;
    end else if (!uart_reset_release || clk_switch_xtal_done) begin
      clock_switch_done <= 1'b0;
    end else if (clk_switch_int_done) begin
      clock_switch_done <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // fifo empty, presence, block guard
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_fifo_empty <= cums_pkg::RX_FIFO_EMPTY_RESET;
      card_present <= 1'b0;
    end else begin
      rx_fifo_empty <= (rx_fifo_level == 4'h0);
      card_present <= pres_sync;
    end
  end

  assign guard_limit = protocol_t1 ? cums_pkg::GUARD_ETU_T1 : cums_pkg::GUARD_ETU_T0;

  cums_guard_timer u_guard (
    .ref_clk(ref_clk),
    .srst(srst),
    .start_bit(start_bit),
    .etu_tick(etu_tick),
    .limit(guard_limit),
    .expired(block_guard_flag)
  );

  // -----------------------------------------------------------------
  // transmit empty / receive full
  // -----------------------------------------------------------------
  // fifo reaches programmed length
  assign rx_full = (rx_fifo_level == ({1'b0, fifo_length} + 4'h1));

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_mode_prev <= 1'b0;
      rx_full_prev <= 1'b0;
      clear_pipe <= '0;
    end else begin
      tx_mode_prev <= tx_mode;
      rx_full_prev <= rx_full;
      clear_pipe <= {clear_pipe[cums_pkg::CLEAR_DELAY_CYCLES-2:0],
                     per_rd_or_wr_data(per_rd, per_wr, per_addr)};
    end
  end

  function automatic logic per_rd_or_wr_data(input logic rd, input logic wr,
                                             input logic [3:0] addr);
    per_rd_or_wr_data = (rd || wr) && (addr == cums_pkg::ADDR_TX_RX_DATA);
  endfunction

  assign set_flag = (tx_mode && !tx_mode_prev)
                  || (tx_char_done && !(last_char_mode && !tx_parity_error))
                  || (rx_full && !rx_full_prev);

  assign clear_flag = clear_pipe[cums_pkg::CLEAR_DELAY_CYCLES-1]
                    || (!tx_mode && tx_mode_prev);

  // set wins over an access clear so a late event is never lost
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_empty_rx_full <= 1'b0;
    end else if (!uart_reset_release) begin
      tx_empty_rx_full <= 1'b0;
    end else if (set_flag) begin
      tx_empty_rx_full <= 1'b1;
    end else if (clear_flag) begin
      tx_empty_rx_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      host_irq_n <= 1'b1;
    end else begin
      host_irq_n <= !(tx_empty_rx_full && !tx_rx_flag_mask);
    end
  end

  // -----------------------------------------------------------------
  // read port
  // -----------------------------------------------------------------
  // unused bits zero
  always_comb begin
    mixed_status_reg = 8'h00;
    mixed_status_reg[cums_pkg::BIT_CLOCK_SWITCH_DONE] = clock_switch_done;
    mixed_status_reg[cums_pkg::BIT_RX_FIFO_EMPTY] = rx_fifo_empty;
    mixed_status_reg[cums_pkg::BIT_BLOCK_GUARD] = block_guard_flag;
    mixed_status_reg[cums_pkg::BIT_CARD_PRESENT] = card_present;
    mixed_status_reg[cums_pkg::BIT_TX_EMPTY_RX_FULL] = tx_empty_rx_full;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      per_rdata <= 8'h00;
    end else if (per_rd) begin
      per_rdata <= (per_addr == cums_pkg::ADDR_MIXED_STATUS) ? mixed_status_reg : 8'h00;
    end
  end
endmodule

// ---- rtl/cums_pkg.sv ----
package cums_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [3:0] ADDR_MIXED_STATUS = 4'hc;
  localparam logic [3:0] ADDR_FIFO_CONTROL = 4'hc;
  localparam logic [3:0] ADDR_TX_RX_DATA = 4'hd;

  // -----------------------------------------------------------------
  // mixed status fields
  // -----------------------------------------------------------------
  localparam int BIT_CLOCK_SWITCH_DONE = 7;
  localparam int BIT_RX_FIFO_EMPTY = 6;
  localparam int BIT_BLOCK_GUARD = 5;
  localparam int BIT_CARD_PRESENT = 2;
  localparam int BIT_TX_EMPTY_RX_FULL = 0;

  // -----------------------------------------------------------------
  // fifo control fields
  // -----------------------------------------------------------------
  localparam int FCR_PEC_LSB = 4;
  localparam int FCR_FL_LSB = 0;
  localparam logic [2:0] FCR_PEC_RESET = 3'h0;
  localparam logic [2:0] FCR_FL_RESET = 3'h0;

  // -----------------------------------------------------------------
  // reset values and timing
  // -----------------------------------------------------------------
  localparam logic RX_FIFO_EMPTY_RESET = 1'b1;
  localparam logic [4:0] GUARD_ETU_T1 = 5'h16;
  localparam logic [4:0] GUARD_ETU_T0 = 5'h10;
  localparam int CLEAR_DELAY_CYCLES = 3;
endpackage

// ---- rtl/cums_guard_timer.sv ----
module cums_guard_timer (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start_bit,
  input wire logic etu_tick,
  input wire logic [4:0] limit,
  output logic expired
);
  logic [4:0] count;
  logic running;

  // -----------------------------------------------------------------
  // etu counter restarted by every start bit
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count <= 5'h00;
      running <= 1'b0;
    end else if (start_bit) begin
      count <= 5'h00;
      running <= 1'b1;
    end else if (running && etu_tick) begin
      count <= count + 5'h01;
      if (count + 5'h01 == limit) begin
        running <= 1'b0;
      end
    end
  end

  // a new start bit drops the flag; expiry sets it until then
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      expired <= 1'b0;
    end else if (start_bit) begin
      expired <= 1'b0;
    end else if (running && etu_tick && (count + 5'h01 == limit)) begin
      expired <= 1'b1;
    end
  end
endmodule

// ---- tb/cums_mixed_status_monitor.sv ----
module cums_mixed_status_monitor (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] per_addr,
  input wire logic per_rd,
  input wire logic per_wr,
  input wire logic [7:0] per_wdata,
  input wire logic [7:0] per_rdata,
  input wire logic uart_reset_release,
  input wire logic tx_mode,
  input wire logic tx_rx_flag_mask,
  input wire logic [2:0] parity_error_count,
  input wire logic [2:0] fifo_length,
  input wire logic tx_data_write,
  input wire logic rx_data_read,
  input wire logic host_irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  unmapped_read_a: assert property (per_rd && per_addr != 4'hc && per_addr != 4'hd
    |=> per_rdata == 8'h00) else $error("unmapped read not zero");
  unused_bits_a: assert property (per_rd && per_addr == 4'hc
    |=> per_rdata[4:3] == 2'h0 && !per_rdata[1]) else $error("unused bits set");
  rdata_hold_a: assert property (!per_rd |=> $stable(per_rdata))
    else $error("read data moved");
  fcr_load_a: assert property (per_wr && per_addr == 4'hc |=>
    fifo_length == $past(per_wdata[2:0]) && parity_error_count == $past(per_wdata[6:4]))
    else $error("fifo control not loaded");
  tx_strobe_a: assert property (per_wr && per_addr == 4'hd |=> tx_data_write)
    else $error("no transmit strobe");
  rx_strobe_a: assert property (per_rd && per_addr == 4'hd |=> rx_data_read)
    else $error("no receive strobe");
  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  reset_irq_a: assert property (!uart_reset_release |=> ##1 host_irq_n)
    else $error("irq low in uart reset");
  mask_irq_a: assert property ($past(tx_rx_flag_mask) |-> host_irq_n)
    else $error("masked irq low");
  tx_enter_a: assert property ($rose(tx_mode) && !tx_rx_flag_mask && uart_reset_release
    ##1 !tx_rx_flag_mask && uart_reset_release |=> !host_irq_n) else $error("no irq on tx");
endmodule
bind cums_mixed_status cums_mixed_status_monitor u_mon (.ref_clk, .srst, .per_addr,
  .per_rd, .per_wr, .per_wdata, .per_rdata, .uart_reset_release, .tx_mode,
  .tx_rx_flag_mask, .parity_error_count, .fifo_length, .tx_data_write, .rx_data_read,
  .host_irq_n);

// ---- tb/cums_card_model.sv ----
module cums_card_model (
  input wire logic ref_clk,
  input wire logic send,
  output logic card_io
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  // line rests high between characters, start bit is a short low
  always_ff @(posedge ref_clk) begin
    if (send) begin
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  assign card_io = (cnt == 3'h0);
endmodule

// ---- tb/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] per_addr = 4'h0;
  logic [3:0] rx_fifo_level = 4'h0;
  logic [7:0] per_wdata = 8'h00;
  logic [7:0] per_rdata, s;
  logic per_rd = 1'b0, per_wr = 1'b0, uart_reset_release = 1'b1, etu_tick = 1'b0;
  logic clk_switch_int_done = 1'b0, clk_switch_xtal_done = 1'b0, protocol_t1 = 1'b0;
  logic tx_mode = 1'b0, tx_char_done = 1'b0, tx_parity_error = 1'b0, last_char_mode = 1'b0;
  logic tx_rx_flag_mask = 1'b0, card_present_pin = 1'b1, card_send = 1'b0, card_io_pin;
  logic [2:0] parity_error_count, fifo_length;
  logic tx_data_write, rx_data_read, host_irq_n;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  cums_mixed_status uut (.ref_clk, .srst, .per_addr, .per_rd, .per_wr, .per_wdata,
    .per_rdata, .uart_reset_release, .clk_switch_int_done, .clk_switch_xtal_done,
    .rx_fifo_level, .etu_tick, .protocol_t1, .tx_mode, .tx_char_done, .tx_parity_error,
    .last_char_mode, .tx_rx_flag_mask, .card_io_pin, .card_present_pin,
    .parity_error_count, .fifo_length, .tx_data_write, .rx_data_read, .host_irq_n);
  cums_card_model card (.ref_clk, .send(card_send), .card_io(card_io_pin));
  initial forever #12.5 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic p);
    @(negedge ref_clk);
    p = 1'b1;
    @(negedge ref_clk);
    p = 1'b0;
    wt(2);
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    per_addr = a;
    per_wdata = d;
    per_rd = !w;
    per_wr = w;
    @(negedge ref_clk);
    per_rd = 1'b0;
    per_wr = 1'b0;
    s = per_rdata;
  endtask
  task rdc(input logic [7:0] e);
    acc(1'b0, 4'hc, 8'h00);
    chk(s, e);
  endtask
  task end_sim;
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim;
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_present;
    wt(4);
    rdc(8'h44);
    acc(1'b0, 4'h3, 8'h00);
    chk(s, 8'h00);
    card_present_pin = 1'b0;
    wt(4);
    rdc(8'h40);
    card_present_pin = 1'b1;
    wt(4);
  endtask
  task t_clock_switch_done;
    pulse(clk_switch_int_done);
    rdc(8'hc4);
    pulse(clk_switch_xtal_done);
    rdc(8'h44);
  endtask
  task t_fifo;
    acc(1'b1, 4'hc, 8'h50);
    chk({1'b0, parity_error_count, 1'b0, fifo_length}, 8'h50);
    rdc(8'h44);
    rx_fifo_level = 4'h1;
    wt(3);
    rdc(8'h05);
    chk({7'h00, host_irq_n}, 8'h00);
    tx_rx_flag_mask = 1'b1;
    wt(2);
    chk({7'h00, host_irq_n}, 8'h01);
    tx_rx_flag_mask = 1'b0;
    acc(1'b0, 4'hd, 8'h00);
    chk({7'h00, rx_data_read}, 8'h01);
    rdc(8'h05);
    rdc(8'h04);
    rx_fifo_level = 4'h0;
    wt(3);
  endtask
  task t_tx;
    tx_mode = 1'b1;
    wt(3);
    rdc(8'h45);
    acc(1'b1, 4'hd, 8'h00);
    chk({7'h00, tx_data_write}, 8'h01);
    wt(4);
    chk({7'h00, tx_data_write}, 8'h00);
    rdc(8'h44);
    last_char_mode = 1'b1;
    pulse(tx_char_done);
    rdc(8'h44);
    tx_parity_error = 1'b1;
    pulse(tx_char_done);
    rdc(8'h45);
    tx_mode = 1'b0;
    wt(3);
    rdc(8'h44);
  endtask
  task t_ureset;
    tx_mode = 1'b1;
    pulse(clk_switch_int_done);
    uart_reset_release = 1'b0;
    wt(3);
    chk({7'h00, host_irq_n}, 8'h01);
    rdc(8'h44);
    uart_reset_release = 1'b1;
    tx_mode = 1'b0;
    wt(3);
  endtask
  task t_guard(input logic t1, input int n);
    protocol_t1 = t1;
    pulse(card_send);
    wt(6);
    rdc(8'h44);
    repeat (n - 1) pulse(etu_tick);
    rdc(8'h44);
    pulse(etu_tick);
    rdc(8'h64);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    t_present();
    t_clock_switch_done();
    t_fifo();
    t_tx();
    t_ureset();
    t_guard(1'b1, 22);
    t_guard(1'b0, 16);
    end_sim();
  end
endmodule
